// ===== verilog/rbk_pkg.sv
// Shared constants and mode type for the configurable embedded RAM block
package rbk_pkg;
  localparam int RBK_SMALL_BITS = 576;
  localparam int RBK_MEDIUM_BITS = 4608;
  localparam int RBK_BYTE_PAR_W = 9;
  localparam int RBK_BYTE_W = 8;
  // Index of each register group in a clock-select vector
  localparam int RBK_SEL_CTRL = 0;
  localparam int RBK_SEL_ADDR = 1;
  localparam int RBK_SEL_BE = 2;
  localparam int RBK_SEL_DATA = 3;
  localparam int RBK_SEL_OUT = 4;
  localparam int RBK_NSEL = 5;
  localparam logic [RBK_NSEL-1:0] RBK_SEL_ALL0 = 5'h00;
  typedef enum logic [2:0] {
    RBK_SINGLE = 3'h0,
    RBK_SDP = 3'h1,
    RBK_TDP = 3'h2,
    RBK_ROM = 3'h3,
    RBK_FIFO = 3'h4,
    RBK_SHIFT = 3'h5
  } rbk_mode_e;
endpackage

// ===== verilog/rbk_port.sv
// One access port: input registers, output register with bypass and clears
`timescale 1ns/1ps
`default_nettype none
module rbk_port import rbk_pkg::*; #(
  parameter int W = 36,
  parameter int AW = 7,
  parameter int BEW = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic tick0,
  input wire logic tick1,
  input wire logic [RBK_NSEL-1:0] clk_sel,
  input wire logic clocken,
  input wire logic in_clr,
  input wire logic out_clr,
  input wire logic out_bypass,
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [BEW-1:0] be,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] rdata_arr,
  output logic [AW-1:0] addr_q,
  output logic [BEW-1:0] be_q,
  output logic [W-1:0] wdata_q,
  output logic wr_stb,
  output logic rd_take,
  output logic [W-1:0] dout
);
  logic we_q, we_d, re_q, re_d, wr_stb_q, wr_stb_d, rd_stb_q, rd_stb_d;
  logic [AW-1:0] addr_d;
  logic [BEW-1:0] be_d;
  logic [W-1:0] wdata_d, dout_q, dout_d;
  logic [RBK_NSEL-1:0] t;
  logic t_out_load;

  // Block clocks arrive as same-domain enables, so fabric logic may drive them
  always_comb begin
    for (int g = 0; g < RBK_NSEL; g++) begin
      t[g] = (clk_sel[g] ? tick1 : tick0) & clocken;
    end
  end

  assign t_out_load = t[RBK_SEL_OUT] & re_q;

  always_comb begin
    we_d = we_q;
    re_d = re_q;
    addr_d = addr_q;
    be_d = be_q;
    wdata_d = wdata_q;
    dout_d = dout_q;
    wr_stb_d = 1'b0;
    rd_stb_d = 1'b0;
    // Input side is always registered; no bypass exists for it
    if (t[RBK_SEL_CTRL]) begin
      we_d = we;
      re_d = re;
      wr_stb_d = we;
      rd_stb_d = re;
    end
    if (t[RBK_SEL_ADDR]) addr_d = addr;
    if (t[RBK_SEL_BE]) be_d = be;
    if (t[RBK_SEL_DATA]) wdata_d = wdata;
    if (t_out_load) dout_d = rdata_arr;
    // Clear wins over any load; read path sees it after this edge
    if (in_clr) begin
      we_d = 1'b0;
      re_d = 1'b0;
      addr_d = '0;
      be_d = '0;
      wdata_d = '0;
      wr_stb_d = 1'b0;
      rd_stb_d = 1'b0;
    end
    if (out_clr) dout_d = '0;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      addr_q <= '0;
      be_q <= '0;
      wdata_q <= '0;
      dout_q <= '0;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
    end else begin
      we_q <= we_d;
      re_q <= re_d;
      addr_q <= addr_d;
      be_q <= be_d;
      wdata_q <= wdata_d;
      dout_q <= dout_d;
      wr_stb_q <= wr_stb_d;
      rd_stb_q <= rd_stb_d;
    end
  end

  assign wr_stb = wr_stb_q;
  // A word counts as consumed when it reaches the output
  assign rd_take = out_bypass ? rd_stb_q : t_out_load;
  // Output clear is seen at once, not at the next edge
  assign dout = out_clr ? '0 : (out_bypass ? rdata_arr : dout_q);
endmodule // rbk_port
`default_nettype wire

// ===== verilog/rbk_ram.sv
// Configurable embedded RAM block in small or medium size
// Operation
// - Small block: 576 bits, no true dual-port
// - Medium block: 4608 bits, all modes
// - Simple dual-port allows differing port widths
// - RAM and ROM preload from init data
// - Input clear acts next edge, output now
// - Output clear seen on output immediately
// - Small block write registers share one clock
// - Small block read registers use either clock
// - Only output register may be bypassed
// - Medium block registers select either clock
// - Medium block has independent ports A, B
`timescale 1ns/1ps
`default_nettype none
module rbk_ram import rbk_pkg::*; #(
  parameter bit SMALL = 1'b0,
  parameter rbk_mode_e MODE = RBK_TDP,
  parameter int WA = 36,
  parameter int WB = 36,
  parameter logic [RBK_NSEL-1:0] CLK_SEL_A = RBK_SEL_ALL0,
  parameter logic [RBK_NSEL-1:0] CLK_SEL_B = RBK_SEL_ALL0,
  parameter int TOTAL = SMALL ? RBK_SMALL_BITS : RBK_MEDIUM_BITS,
  parameter logic [TOTAL-1:0] INIT = '0,
  parameter int BYTE_A = (WA % RBK_BYTE_PAR_W == 0) ? RBK_BYTE_PAR_W : RBK_BYTE_W,
  parameter int BYTE_B = (WB % RBK_BYTE_PAR_W == 0) ? RBK_BYTE_PAR_W : RBK_BYTE_W,
  parameter int BEA = (WA >= BYTE_A) ? WA / BYTE_A : 1,
  parameter int BEB = (WB >= BYTE_B) ? WB / BYTE_B : 1,
  parameter int AWA = $clog2(TOTAL / WA),
  parameter int AWB = $clog2(TOTAL / WB)
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic blk_tick0,
  input wire logic blk_tick1,
  input wire logic a_clocken,
  input wire logic a_in_clr,
  input wire logic a_out_clr,
  input wire logic a_out_bypass,
  input wire logic a_we,
  input wire logic a_re,
  input wire logic [AWA-1:0] a_addr,
  input wire logic [BEA-1:0] a_be,
  input wire logic [WA-1:0] a_wdata,
  output logic [WA-1:0] a_dout,
  input wire logic b_clocken,
  input wire logic b_in_clr,
  input wire logic b_out_clr,
  input wire logic b_out_bypass,
  input wire logic b_we,
  input wire logic b_re,
  input wire logic [AWB-1:0] b_addr,
  input wire logic [BEB-1:0] b_be,
  input wire logic [WB-1:0] b_wdata,
  output logic [WB-1:0] b_dout,
  output logic fifo_full,
  output logic fifo_empty
);
  localparam int PW = $clog2(TOTAL + 1);
  // Small block cannot act as true dual-port; fall back to one writer
  localparam rbk_mode_e MODE_EFF = (SMALL && MODE == RBK_TDP) ? RBK_SDP : MODE;
  // Small block ties all port A register groups to its control clock
  localparam logic [RBK_NSEL-1:0] SEL_A_EFF =
      SMALL ? {RBK_NSEL{CLK_SEL_A[RBK_SEL_CTRL]}} : CLK_SEL_A;
  localparam bit PTR_MODE = (MODE_EFF == RBK_FIFO) || (MODE_EFF == RBK_SHIFT);

  logic [TOTAL-1:0] mem_q, mem_d;
  logic [PW-1:0] wptr_q, wptr_d, rptr_q, rptr_d, fill_q, fill_d;
  logic [AWA-1:0] addr_a_q;
  logic [AWB-1:0] addr_b_q;
  logic [BEA-1:0] be_a_q;
  logic [BEB-1:0] be_b_q;
  logic [WA-1:0] wdata_a_q, rd_a;
  logic [WB-1:0] wdata_b_q, rd_b;
  logic wr_stb_a, wr_stb_b, take_b, wa_ok, wb_ok, rb_ok;
  int base_a, base_b;

  // Port A and port B each keep their own clock enable, strobes and clears
  rbk_port #(.W(WA), .AW(AWA), .BEW(BEA)) u_port_a (
    .mclk(mclk),
    .rstn(rstn),
    .tick0(blk_tick0),
    .tick1(blk_tick1),
    .clk_sel(SEL_A_EFF),
    .clocken(a_clocken),
    .in_clr(a_in_clr),
    .out_clr(a_out_clr),
    .out_bypass(a_out_bypass),
    .we(a_we),
    .re(a_re),
    .addr(a_addr),
    .be(a_be),
    .wdata(a_wdata),
    .rdata_arr(rd_a),
    .addr_q(addr_a_q),
    .be_q(be_a_q),
    .wdata_q(wdata_a_q),
    .wr_stb(wr_stb_a),
    .rd_take(),
    .dout(a_dout)
  );

  // Read-side groups of port B are free to pick either clock
  rbk_port #(.W(WB), .AW(AWB), .BEW(BEB)) u_port_b (
    .mclk(mclk),
    .rstn(rstn),
    .tick0(blk_tick0),
    .tick1(blk_tick1),
    .clk_sel(CLK_SEL_B),
    .clocken(b_clocken),
    .in_clr(b_in_clr),
    .out_clr(b_out_clr),
    .out_bypass(b_out_bypass),
    .we(b_we),
    .re(b_re),
    .addr(b_addr),
    .be(b_be),
    .wdata(b_wdata),
    .rdata_arr(rd_b),
    .addr_q(addr_b_q),
    .be_q(be_b_q),
    .wdata_q(wdata_b_q),
    .wr_stb(wr_stb_b),
    .rd_take(take_b),
    .dout(b_dout)
  );

  assign fifo_full = (int'(fill_q) + WA) > TOTAL;
  assign fifo_empty = int'(fill_q) < WB;

  // Per-mode access permissions, decoded once from the effective mode
  logic a_wr_allow, b_wr_allow, b_pop_allow;
  always_comb begin
    a_wr_allow = 1'b1;
    b_wr_allow = 1'b0;
    b_pop_allow = 1'b0;
    case (MODE_EFF)
      RBK_ROM: begin
        // Contents come only from the preload
        a_wr_allow = 1'b0;
      end
      RBK_TDP: begin
        b_wr_allow = 1'b1;
      end
      RBK_FIFO: begin
        // Full drops the push, empty holds the pop pointer
        a_wr_allow = !fifo_full;
        b_pop_allow = !fifo_empty;
      end
      default: begin
        a_wr_allow = 1'b1;
      end
    endcase
  end

  assign wa_ok = wr_stb_a && a_wr_allow;
  assign wb_ok = wr_stb_b && b_wr_allow;
  assign rb_ok = take_b && b_pop_allow;

  // Both ports address one bit array, each in units of its own width
  always_comb begin
    base_a = PTR_MODE ? int'(wptr_q) : int'(addr_a_q) * WA;
    case (MODE_EFF)
      RBK_FIFO: base_b = int'(rptr_q);
      RBK_SHIFT: base_b = int'(wptr_q);
      default: base_b = int'(addr_b_q) * WB;
    endcase
  end

  // Mixed-port read returns old array contents; users must not rely on it
  always_comb begin
    for (int i = 0; i < WA; i++) begin
      rd_a[i] = mem_q[(base_a + i) % TOTAL];
    end
    for (int i = 0; i < WB; i++) begin
      rd_b[i] = mem_q[(base_b + i) % TOTAL];
    end
  end

  always_comb begin
    mem_d = mem_q;
    // Port B is applied last, so it wins a same-bit collision
    for (int i = 0; i < WA; i++) begin
      if (wa_ok && be_a_q[(i / BYTE_A) % BEA]) mem_d[(base_a + i) % TOTAL] = wdata_a_q[i];
    end
    for (int i = 0; i < WB; i++) begin
      if (wb_ok && be_b_q[(i / BYTE_B) % BEB]) mem_d[(base_b + i) % TOTAL] = wdata_b_q[i];
    end
  end

  // Pointers count bits, so mixed widths also work in FIFO mode
  always_comb begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    fill_d = fill_q;
    if (PTR_MODE && wa_ok) begin
      wptr_d = PW'((int'(wptr_q) + WA) % TOTAL);
    end
    if (rb_ok) begin
      rptr_d = PW'((int'(rptr_q) + WB) % TOTAL);
    end
    if (MODE_EFF == RBK_FIFO) begin
      fill_d = PW'(int'(fill_q) + (wa_ok ? WA : 0) - (rb_ok ? WB : 0));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mem_q <= INIT;
      wptr_q <= '0;
      rptr_q <= '0;
      fill_q <= '0;
    end else begin
      mem_q <= mem_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      fill_q <= fill_d;
    end
  end
endmodule // rbk_ram
`default_nettype wire

// ===== tb/rbk_ram_chk.sv
// Port assertions for the embedded RAM block
`timescale 1ns/1ps
`default_nettype none
module rbk_ram_chk #(
  parameter int WA = 36,
  parameter int WB = 36
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic blk_tick0,
  input wire logic a_clocken,
  input wire logic b_clocken,
  input wire logic b_in_clr,
  input wire logic a_out_clr,
  input wire logic b_out_clr,
  input wire logic a_out_bypass,
  input wire logic b_out_bypass,
  input wire logic a_we,
  input wire logic b_we,
  input wire logic a_re,
  input wire logic b_re,
  input wire logic [WA-1:0] a_dout,
  input wire logic [WB-1:0] b_dout
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Registered output visible, no clear
  wire logic qa = !a_out_clr && !a_out_bypass;
  wire logic qb = !b_out_clr && !b_out_bypass;
  sequence s_qa2; qa ##1 qa; endsequence
  sequence s_qb2; qb ##1 qb; endsequence
  AST_OCLR_A: assert property (a_out_clr |-> a_dout == '0)
    else $error("a_dout not zero under clear");
  AST_OCLR_B: assert property (b_out_clr |-> b_dout == '0)
    else $error("b_dout not zero under clear");
  AST_OREG_B: assert property (b_out_clr ##1 qb |-> b_dout == '0)
    else $error("b_dout kept data after clear");
  AST_HOLD_A:
    assert property ((!a_re && a_clocken && blk_tick0) ##1 s_qa2 |-> $stable(a_dout))
    else $error("a_dout moved without a read");
  AST_HOLD_B:
    assert property ((!b_re && b_clocken && blk_tick0) ##1 s_qb2 |-> $stable(b_dout))
    else $error("b_dout moved without a read");
  AST_ICLR_B: assert property (b_in_clr ##1 s_qb2 |-> $stable(b_dout))
    else $error("b_dout moved after input clear");
  AST_BYP_B:
    assert property ((b_re && b_clocken && blk_tick0 && !b_in_clr && !a_we && !b_we)
      ##1 (b_out_bypass && !b_out_clr && !b_in_clr && b_clocken && blk_tick0)
      ##1 qb |-> $stable(b_dout))
    else $error("bypass and registered data differ");
  AST_RST: assert property ($rose(rstn) && qa && qb |-> a_dout == '0 && b_dout == '0)
    else $error("outputs not cleared by reset");
endmodule // rbk_ram_chk
bind rbk_ram rbk_ram_chk #(.WA(WA), .WB(WB)) i_chk (.*);
`default_nettype wire

// ===== tb/rbk_user.sv
// Fabric user logic model driving port B requests
`timescale 1ns/1ps
`default_nettype none
module rbk_user (
  input wire logic mclk,
  input wire logic rd,
  input wire logic wr,
  input wire logic [6:0] addr,
  output logic b_re,
  output logic b_we,
  output logic [6:0] b_addr
);
  logic [6:0] last_q = '0;
  always_ff @(posedge mclk) if (rd || wr) last_q <= addr;
  // Strobes straight from logic cells, own port
  assign b_re = rd;
  assign b_we = wr;
  // Idle address inverted so no stale value is leaned on
  assign b_addr = (rd || wr) ? addr : ~last_q;
endmodule // rbk_user
`default_nettype wire

// ===== tb/rbk_ram_tb.sv
// Self-checking bench for the embedded RAM block
`timescale 1ns/1ps
`default_nettype none
module rbk_ram_tb import rbk_pkg::*;;
  localparam logic [35:0] IV = 36'h5a5a5a5a5;
  localparam logic [35:0] RIV = 36'h2468ace13;
  logic mclk, rstn, tk0, tk1, ace, bce, aic, bic, aoc, boc, aby, bby;
  logic awe, are, prd, pwr, bwe, bre;
  logic [6:0] aad, pad, bad, ra;
  logic [3:0] abe, bbe;
  logic [35:0] awd, bwd, ado, bdo;
  logic [17:0] rao, rbo;
  logic dff, dfe;
  logic [35:0] mem [128];
  int err_total, num_checks;
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  rbk_ram #(.INIT({128{IV}})) i_dut (
    .mclk(mclk), .rstn(rstn), .blk_tick0(tk0), .blk_tick1(tk1),
    .a_clocken(ace), .a_in_clr(aic), .a_out_clr(aoc), .a_out_bypass(aby),
    .a_we(awe), .a_re(are), .a_addr(aad), .a_be(abe), .a_wdata(awd), .a_dout(ado),
    .b_clocken(bce), .b_in_clr(bic), .b_out_clr(boc), .b_out_bypass(bby),
    .b_we(bwe), .b_re(bre), .b_addr(bad), .b_be(bbe), .b_wdata(bwd), .b_dout(bdo),
    .fifo_full(dff), .fifo_empty(dfe)
  );
  // Small block as ROM: every write refused, words stay as preloaded
  rbk_ram #(.SMALL(1'b1), .MODE(RBK_ROM), .WA(18), .WB(18), .INIT({16{RIV}})) i_rom (
    .mclk(mclk), .rstn(rstn), .blk_tick0(tk0), .blk_tick1(tk1),
    .a_clocken(ace), .a_in_clr(aic), .a_out_clr(aoc), .a_out_bypass(aby),
    .a_we(awe), .a_re(are), .a_addr(aad[4:0]), .a_be(abe[1:0]), .a_wdata(awd[17:0]),
    .a_dout(rao),
    .b_clocken(bce), .b_in_clr(bic), .b_out_clr(boc), .b_out_bypass(bby),
    .b_we(bwe), .b_re(bre), .b_addr(bad[4:0]), .b_be(bbe[1:0]), .b_wdata(bwd[17:0]),
    .b_dout(rbo), .fifo_full(), .fifo_empty()
  );
  rbk_user i_usr (.mclk(mclk), .rd(prd), .wr(pwr), .addr(pad), .b_re(bre), .b_we(bwe),
    .b_addr(bad));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic p, input logic [6:0] ad, input logic [35:0] d,
    input logic [3:0] be, input logic clr);
    @(negedge mclk);
    if (p) {pwr, pad, bwd, bbe, bic} = {1'b1, ad, d, be, clr};
    else {awe, aad, awd, abe} = {1'b1, ad, d, be};
    @(negedge mclk);
    {awe, pwr, bic} = '0;
    {aad, awd, bwd} = ~{aad, awd, bwd};
    for (int i = 0; i < 4; i++) begin
      if (be[i] && !clr) mem[ad][i*RBK_BYTE_PAR_W +: RBK_BYTE_PAR_W] = d[i*9 +: 9];
    end
  endtask
  task automatic rd(input logic p, input logic [6:0] ad, input logic byp);
    @(negedge mclk);
    if (p) {prd, pad, bby} = {1'b1, ad, byp};
    else {are, aad, aby} = {1'b1, ad, byp};
    @(negedge mclk);
    {prd, are} = '0;
    aad = ~aad;
    if (!byp) @(negedge mclk);
    chk(p ? bdo : ado, mem[ad]);
    chk(36'(p ? rbo : rao), 36'(ad[0] ? RIV[35:18] : RIV[17:0]));
    // Bypass kept one more cycle so the registered copy can be compared
    if (byp) @(negedge mclk);
    {aby, bby} = '0;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_sim;
  end
  initial begin
    {rstn, aic, bic, aoc, boc, aby, bby, awe, are, prd, pwr} = '0;
    {tk0, tk1, ace, bce} = '1;
    {aad, pad, abe, bbe, awd, bwd} = '0;
    err_total = 0;
    num_checks = 0;
    foreach (mem[i]) mem[i] = IV;
    void'($urandom(54));
    repeat (8) @(negedge mclk);
    rstn = 1;
    chk(ado, '0);
    chk(bdo, '0);
    chk(36'({dff, dfe}), 36'h1);
    rd(1'b0, 7'h05, 1'b0);
    rd(1'b1, 7'h7f, 1'b1);
    for (int n = 0; n < 32; n++) begin
      ra = 7'($urandom());
      wr(1'($urandom()), ra, 36'({$urandom(), $urandom()}), 4'($urandom()), 1'b0);
      rd(1'($urandom()), ra, n[0]);
    end
    // Writes now held off for four reads; stored words must read back unchanged
    for (int n = 0; n < 4; n++) begin
      rd(1'($urandom()), 7'($urandom()), n[0]);
    end
    // Write under input clear must not land
    wr(1'b1, 7'h10, 36'h123456789, 4'hf, 1'b1);
    rd(1'b1, 7'h10, 1'b0);
    @(negedge mclk);
    {aoc, boc} = 2'h3;
    #1;
    chk(ado, '0);
    chk(bdo, '0);
    @(negedge mclk);
    {aoc, boc} = '0;
    #1;
    chk(bdo, '0);
    @(negedge mclk);
    chk(ado, '0);
    end_sim;
  end
endmodule // rbk_ram_tb
`default_nettype wire
